// ===== dtdp_dual_tap_debug_port.sv
// Dual TAP chain, serial debug switch and bus access port front end
`timescale 1ns/1ps
`default_nettype none
module dtdp_dual_tap_debug_port #(
    parameter logic [31:0] CORE_IDCODE = 32'h1234_5677  // Arbitrary value
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    jtagResetPinN,
    input  wire logic                    jtagInPin,
    output logic                         jtagOutPin,
    output logic                         jtagOutPinOe,
    input  wire logic                    modeSelPinIn,
    output logic                         modeSelPinOut,
    output logic                         modeSelPinOe,
    input  wire logic                    clockPin,
    output logic                         busValid,
    input  wire logic                    busReady,
    output dtdp_pkg::dtdp_bus_req_t      busReq,
    input  wire logic [dtdp_pkg::BUS_DW-1:0] busRdata,
    output logic                         haltReq,
    output logic                         stepReq,
    output logic                         swMode
);
    import dtdp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [1:0]         tckS;
        logic [1:0]         tmsS;
        logic [1:0]         tdiS;
        logic [1:0]         rstS;
        logic               tckPrev;
        dtdp_tap_st_t       tstSt;
        logic [IR_W-1:0]    tstIr;
        logic [IR_W-1:0]    tstIrSh;
        logic               tstByp;
        dtdp_tap_st_t       corSt;
        logic [IR_W-1:0]    corIr;
        logic [IR_W-1:0]    corIrSh;
        logic               corByp;
        logic [DR_W-1:0]    corDr;
        logic               tdo;
        logic               tdoOe;
        logic               sw;
        logic [ONES_W-1:0]  ones;
        logic               coll;
        logic [3:0]         seqCnt;
        logic [SEQ_W-1:0]   seq;
        logic               bValid;
        dtdp_bus_req_t      bReq;
        logic [BUS_DW-1:0]  rdata;
        logic               halt;
        logic               step;
    } dtdp_state_t;

    dtdp_state_t q, d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic dtdp_tap_st_t tapNext(input dtdp_tap_st_t s, input logic tms);
        case (s)
            TS_RESET:    tapNext = tms ? TS_RESET    : TS_IDLE;
            TS_IDLE:     tapNext = tms ? TS_SEL_DR   : TS_IDLE;
            TS_SEL_DR:   tapNext = tms ? TS_SEL_IR   : TS_CAP_DR;
            TS_CAP_DR:   tapNext = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: tapNext = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: tapNext = tms ? TS_UPD_DR   : TS_PAUSE_DR;
            TS_PAUSE_DR: tapNext = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: tapNext = tms ? TS_UPD_DR   : TS_SHIFT_DR;
            TS_UPD_DR:   tapNext = tms ? TS_SEL_DR   : TS_IDLE;
            TS_SEL_IR:   tapNext = tms ? TS_RESET    : TS_CAP_IR;
            TS_CAP_IR:   tapNext = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: tapNext = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: tapNext = tms ? TS_UPD_IR   : TS_PAUSE_IR;
            TS_PAUSE_IR: tapNext = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: tapNext = tms ? TS_UPD_IR   : TS_SHIFT_IR;
            TS_UPD_IR:   tapNext = tms ? TS_SEL_DR   : TS_IDLE;
            default:     tapNext = TS_RESET;
        endcase
    endfunction

    function automatic int drLen(input logic [IR_W-1:0] ir);
        case (ir)
            INS_IDCODE:  drLen = IDC_DR_LEN;
            INS_BUSADDR: drLen = ADDR_DR_LEN;
            INS_BUSDATA: drLen = DATA_DR_LEN;
            INS_CTRL:    drLen = CTRL_DR_LEN;
            default:     drLen = 1;
        endcase
    endfunction

    function automatic logic isByp(input logic [IR_W-1:0] ir);
        isByp = (drLen(ir) == 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link sampling and edges
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    logic tstTms;
    logic tstOut;
    logic jtagRst;

    assign rise    = q.tckS[1] & ~q.tckPrev;
    assign fall    = ~q.tckS[1] & q.tckPrev;
    assign tms     = q.tmsS[1];
    assign tdi     = q.tdiS[1];
    assign jtagRst = ~q.rstS[1];
    assign tstTms  = q.sw ? 1'b1 : tms;  // [R5]
    assign tstOut  = (q.tstSt == TS_SHIFT_IR) ? q.tstIrSh[0] : q.tstByp;  // [R1]

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        d.tckS    = {q.tckS[0], clockPin};
        d.tmsS    = {q.tmsS[0], modeSelPinIn};
        d.tdiS    = {q.tdiS[0], jtagInPin};
        d.rstS    = {q.rstS[0], jtagResetPinN};
        d.tckPrev = q.tckS[1];
        d.step    = 1'b0;
        if (q.bValid && busReady) begin  // [R8]
            d.bValid = 1'b0;
            if (!q.bReq.write) begin
                d.rdata = busRdata;
            end
        end
        if (rise) begin
            // Test TAP: first in chain, fed from data in
            d.tstSt = tapNext(q.tstSt, tstTms);  // [R1] [R5]
            case (q.tstSt)
                TS_CAP_IR:   d.tstIrSh = IR_CAPTURE;
                TS_SHIFT_IR: d.tstIrSh = {tdi, q.tstIrSh[IR_W-1:1]};  // [R3]
                TS_UPD_IR:   d.tstIr = q.tstIrSh;
                TS_CAP_DR:   d.tstByp = 1'b0;
                TS_SHIFT_DR: d.tstByp = tdi;  // [R4] [R10]
                default:     d.tstIr = q.tstIr;
            endcase
            // Core TAP: second in chain, fed from test TAP
            d.corSt = tapNext(q.corSt, tms);  // [R1]
            case (q.corSt)
                TS_CAP_IR:   d.corIrSh = IR_CAPTURE;
                TS_SHIFT_IR: d.corIrSh = {tstOut, q.corIrSh[IR_W-1:1]};  // [R3]
                TS_UPD_IR:   d.corIr = q.corIrSh;
                TS_CAP_DR: begin
                    d.corByp = 1'b0;
                    case (q.corIr)
                        INS_IDCODE:  d.corDr = {1'b0, CORE_IDCODE};
                        INS_BUSADDR: d.corDr = {1'b0, q.bReq.addr};
                        INS_BUSDATA: d.corDr = {q.bValid, q.rdata};  // [R9]
                        INS_CTRL:    d.corDr = {31'h0000_0000, q.step, q.halt};
                        default:     d.corDr = q.corDr;
                    endcase
                end
                TS_SHIFT_DR: begin
                    if (isByp(q.corIr)) begin
                        d.corByp = tstOut;  // [R4] [R10]
                    end else begin
                        d.corDr = q.corDr >> 1;
                        d.corDr[drLen(q.corIr)-1] = tstOut;
                    end
                end
                TS_UPD_DR: begin
                    case (q.corIr)
                        INS_BUSADDR: d.bReq.addr = q.corDr[BUS_AW-1:0];
                        INS_BUSDATA: begin
                            if (!q.bValid) begin  // [R8] [R9]
                                d.bValid      = 1'b1;
                                d.bReq.write  = ~q.corDr[DATA_RNW_BIT];
                                d.bReq.wdata  = q.corDr[BUS_DW-1:0];
                            end
                        end
                        INS_CTRL: begin
                            d.halt = q.corDr[CTRL_HALT_BIT];  // [R9]
                            d.step = q.corDr[CTRL_STEP_BIT];
                        end
                        default: d.halt = q.halt;
                    endcase
                end
                default: d.corIr = q.corIr;
            endcase
            // Switching sequence on the shared mode-select pin
            if (q.coll) begin  // [R6]
                d.seq    = {tms, q.seq[SEQ_W-1:1]};
                d.seqCnt = q.seqCnt + 4'h1;
                if (q.seqCnt == 4'hF) begin
                    d.coll = 1'b0;
                    if (!q.sw && d.seq == SEQ_TO_SW) begin
                        d.sw = 1'b1;
                    end else if (q.sw && d.seq == SEQ_TO_JTAG) begin
                        d.sw = 1'b0;
                    end
                end
                d.ones = '0;
            end else if (tms) begin
                if (q.ones != ONES_W'(ONES_MIN)) begin
                    d.ones = q.ones + 6'h01;
                end
            end else begin
                if (q.ones == ONES_W'(ONES_MIN)) begin
                    d.coll   = 1'b1;
                    d.seq    = {1'b0, q.seq[SEQ_W-1:1]};
                    d.seqCnt = 4'h1;
                end
                d.ones = '0;
            end
        end
        if (fall) begin
            d.tdoOe = !q.sw && (q.corSt == TS_SHIFT_IR || q.corSt == TS_SHIFT_DR);  // [R7]
            if (q.corSt == TS_SHIFT_IR) begin
                d.tdo = q.corIrSh[0];
            end else if (q.corSt == TS_SHIFT_DR) begin
                d.tdo = isByp(q.corIr) ? q.corByp : q.corDr[0];
            end
        end
        if (jtagRst) begin
            d.tstSt = TS_RESET;
            d.corSt = TS_RESET;
        end
        if (q.tstSt == TS_RESET) begin
            d.tstIr = INS_BYPASS;  // [R10]
        end
        if (q.corSt == TS_RESET) begin
            d.corIr = INS_IDCODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '{tckS: 2'h0, tmsS: 2'h3, tdiS: 2'h0, rstS: 2'h3, tckPrev: 1'b0,
                   tstSt: TS_RESET, tstIr: INS_BYPASS, tstIrSh: 4'h0, tstByp: 1'b0,
                   corSt: TS_RESET, corIr: INS_IDCODE, corIrSh: 4'h0, corByp: 1'b0,
                   corDr: 33'h0_0000_0000, tdo: 1'b0, tdoOe: 1'b0, sw: 1'b0,
                   ones: 6'h00, coll: 1'b0, seqCnt: 4'h0, seq: 16'h0000,
                   bValid: 1'b0, bReq: '0, rdata: 32'h0000_0000, halt: 1'b0, step: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign jtagOutPin    = q.tdo;
    assign jtagOutPinOe  = q.tdoOe;
    assign modeSelPinOut = 1'b0;
    assign modeSelPinOe  = 1'b0;
    assign busValid      = q.bValid;
    assign busReq        = q.bReq;
    assign haltReq       = q.halt;
    assign stepReq       = q.step;
    assign swMode        = q.sw;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_test_tap_held: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R5]
        q.sw && q.tstSt == TS_RESET |=> q.tstSt == TS_RESET && q.tstIr == INS_BYPASS)
        else $error("test TAP left reset in serial mode");

    a_reset_pin_tlr: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R1]
        jtagRst |=> q.tstSt == TS_RESET && q.corSt == TS_RESET)
        else $error("TAPs not reset by reset pin");

    a_bypass_one_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R4]
        rise && q.tstSt == TS_SHIFT_DR |=> q.tstByp == $past(tdi))
        else $error("test bypass stage wrong");

    a_ir_chain_link: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R3]
        rise && q.corSt == TS_SHIFT_IR && q.tstSt == TS_SHIFT_IR
        |=> q.corIrSh[IR_W-1] == $past(q.tstIrSh[0]))
        else $error("IR chain not linked");

    a_bus_held: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R8]
        busValid && !busReady |=> busValid && $stable(busReq))
        else $error("bus request dropped");

    a_bus_issue: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R8]
        rise && q.corSt == TS_UPD_DR && q.corIr == INS_BUSDATA && !busValid |=> busValid)
        else $error("bus request not issued");

    a_halt_update: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R9]
        rise && q.corSt == TS_UPD_DR && q.corIr == INS_CTRL
        |=> haltReq == $past(q.corDr[CTRL_HALT_BIT]) && stepReq == $past(q.corDr[CTRL_STEP_BIT]) ##1 !stepReq)
        else $error("halt or step wrong");

    a_tdo_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R7]
        fall && !swMode && q.corSt == TS_SHIFT_IR |=> jtagOutPinOe && jtagOutPin == $past(q.corIrSh[0]))
        else $error("data out not driven");

    a_sw_select: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [R6]
        rise && q.coll && q.seqCnt == 4'hF && !swMode && {tms, q.seq[SEQ_W-1:1]} == SEQ_TO_SW |=> swMode)
        else $error("serial mode not selected");

endmodule // dtdp_dual_tap_debug_port
`default_nettype wire

// ===== dtdp_dual_tap_debug_port_tb.sv
// Self-checking bench of the dual TAP debug port
`timescale 1ns/1ps
`default_nettype none
module dtdp_dual_tap_debug_port_tb;
    import dtdp_pkg::*;
    localparam logic [31:0] IDC = 32'h5A3C_0E11;  // Arbitrary value
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              busReady = 1'b0;
    logic [BUS_DW-1:0] busRdata = '0;
    logic              tck, tms, tdi, trstN, jtagOutPin, jtagOutPinOe, modeSelPinOut, modeSelPinOe;
    logic              busValid, haltReq, stepReq, swMode, prevValid;
    dtdp_bus_req_t     busReq, prevReq, lastReq;
    int                err_total = 0, n_compared = 0, nXfer = 0, nStep = 0, nOe = 0;
    wire logic         modeSelLine = modeSelPinOe ? modeSelPinOut : tms;
    wire logic         tdoLine = jtagOutPinOe ? jtagOutPin : ~jtagOutPin;

    dtdp_dual_tap_debug_port #(.CORE_IDCODE(IDC)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .jtagResetPinN(trstN), .jtagInPin(tdi),
        .jtagOutPin(jtagOutPin), .jtagOutPinOe(jtagOutPinOe), .modeSelPinIn(modeSelLine),
        .modeSelPinOut(modeSelPinOut), .modeSelPinOe(modeSelPinOe), .clockPin(tck),
        .busValid(busValid), .busReady(busReady), .busReq(busReq), .busRdata(busRdata),
        .haltReq(haltReq), .stepReq(stepReq), .swMode(swMode)
    );
    dtdp_probe_model probe (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdoLine));

    always #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Bus responder with random stalls, and monitors
    always @(posedge sys_clk) begin
        if (busValid && prevValid) chk(busReq, prevReq, "request moved while valid");
        prevValid <= busValid;
        prevReq   <= busReq;
        if (stepReq === 1'b1) nStep <= nStep + 1;
        if (jtagOutPinOe === 1'b1) nOe <= nOe + 1;
        if (busValid && busReady) begin
            lastReq  <= busReq;
            nXfer    <= nXfer + 1;
            busReady <= 1'b0;
        end else begin
            busReady <= busValid && ($urandom_range(0, 1) == 1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s, seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Compared %0d values, %0d wrong", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic waitXfer(input int target);
        for (int k = 0; k < 400 && nXfer != target; k++) @(posedge sys_clk);
        if (nXfer != target) begin
            chk(nXfer, target, "bus transfer timeout");
            wrap_up();
        end
    endtask
    function automatic logic [63:0] irWord(input logic [IR_W-1:0] coreIns);
        return {56'h0, INS_BYPASS, coreIns};
    endfunction
    function automatic logic [63:0] chainOut(input logic [63:0] din, input int n, input int stages);
        return (din << stages) & ((64'h1 << n) - 64'h1);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] d;
        logic [63:0] din;
        logic [31:0] addr, wd, rdVal;
        int          s0;
        void'($urandom(94126));
        repeat (15) @(posedge sys_clk);
        chk({busValid, haltReq, stepReq, swMode, jtagOutPinOe}, '0, "outputs in reset");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        probe.tapReset(1'b0);
        probe.scan(1'b0, 33, '0, d);
        chk(d[32:0], {1'b0, IDC}, "id after reset");
        probe.scan(1'b1, 8, irWord(INS_BYPASS), d);
        chk(d[7:0], {IR_CAPTURE, IR_CAPTURE}, "ir capture");
        for (int k = 0; k < 2; k++) begin
            din = (k == 0) ? 64'hFF_FFFF : {40'h0, 24'($urandom)};
            if (k == 1) probe.scan(1'b1, 8, irWord(4'h3), d);
            probe.scan(1'b0, 24, din, d);
            chk(d, chainOut(din, 24, 2), "two bypass stages");
        end
        chk(nOe > 0, 1'b1, "data out driven in shift");
        probe.scan(1'b1, 8, irWord(INS_IDCODE), d);
        probe.scan(1'b0, 33, '0, d);
        chk(d[32:0], {1'b0, IDC}, "id through chain");
        addr = $urandom;
        wd   = $urandom;
        probe.scan(1'b1, 8, irWord(INS_BUSADDR), d);
        probe.scan(1'b0, 33, {32'h0, addr}, d);
        probe.scan(1'b1, 8, irWord(INS_BUSDATA), d);
        probe.scan(1'b0, 34, {32'h0, wd}, d);
        waitXfer(1);
        chk(lastReq, {1'b1, addr, wd}, "bus write");
        @(posedge sys_clk);
        rdVal = $urandom;
        busRdata <= rdVal;
        for (int k = 2; k < 4; k++) begin
            probe.scan(1'b0, 34, {31'h0, 1'b1, 32'h0}, d);
            waitXfer(k);
            chk({lastReq.write, lastReq.addr}, {1'b0, addr}, "bus read");
        end
        chk(d[32:0], {1'b0, rdVal}, "read data");
        probe.scan(1'b1, 8, irWord(INS_CTRL), d);
        s0 = nStep;
        probe.scan(1'b0, 3, 64'h3, d);
        chk({haltReq, 32'(nStep - s0)}, {1'b1, 32'd1}, "halt and one step");
        probe.scan(1'b0, 3, 64'h0, d);
        chk({haltReq, 32'(nStep - s0)}, {1'b0, 32'd1}, "resume");
        s0 = nOe;
        probe.switchSeq(SEQ_TO_SW);
        repeat (4) @(posedge sys_clk);
        chk(swMode, 1'b1, "serial selected");
        probe.tapReset(1'b0);
        probe.scan(1'b1, 8, irWord(INS_IDCODE), d);
        chk(nOe - s0, 0, "data out silent in serial mode");
        chk({modeSelPinOe, modeSelPinOut}, 2'b00, "serial pin not driven");
        probe.switchSeq(SEQ_TO_JTAG);
        repeat (4) @(posedge sys_clk);
        chk(swMode, 1'b0, "jtag selected again");
        probe.tapReset(1'b0);
        probe.scan(1'b1, 8, irWord(INS_BYPASS), d);
        chk(d[7:0], {IR_CAPTURE, IR_CAPTURE}, "ir capture after switch back");
        probe.tapReset(1'b1);
        probe.scan(1'b0, 33, '0, d);
        chk(d[32:0], {1'b0, IDC}, "id after pin reset");
        chk(nXfer, 3, "no stray bus traffic");
        wrap_up();
    end
endmodule // dtdp_dual_tap_debug_port_tb
`default_nettype wire

// ===== dtdp_pkg.sv
// Package of constants and types for the dual TAP debug port
// Function
// (R1) Two TAP controllers sit in series on the JTAG pins, test TAP first, then the core TAP, each with a 4-bit IR.
// (R2) The probe loads BYPASS into the test TAP before it talks to the core TAP.
// (R3) Every IR scan spans 8 bits across both TAPs, with BYPASS in the field of the unused TAP.
// (R4) A TAP in bypass adds exactly one bit to a data scan and the probe allows for it.
// (R5) Once the switching sequence selects serial debug, the test TAP sees its mode-select input held high.
// (R6) Serial data and clock share pins with JTAG mode-select and clock so the probe can switch without rewiring.
// (R7) The debug function uses five shared pins: reset, data out, data in, mode-select or serial data, clock.
// (R8) The debug port passes probe requests to a bus access port that performs transfers on the system bus.
// (R9) The debug path allows non-intrusive memory and register access and processor halt and single step.
// (R10) Each bypass register is one stage between data in and data out while BYPASS is the instruction.
package dtdp_pkg;

    localparam int IR_W        = 4;
    localparam int BUS_AW      = 32;
    localparam int BUS_DW      = 32;
    localparam int DR_W        = 33;
    localparam int ADDR_DR_LEN = 32;
    localparam int DATA_DR_LEN = 33;
    localparam int CTRL_DR_LEN = 2;
    localparam int IDC_DR_LEN  = 32;
    localparam int ONES_MIN    = 50;
    localparam int ONES_W      = 6;
    localparam int SEQ_W       = 16;

    localparam logic [IR_W-1:0]  INS_BYPASS  = 4'hF;
    localparam logic [IR_W-1:0]  INS_IDCODE  = 4'hE;
    localparam logic [IR_W-1:0]  INS_BUSADDR = 4'h8;
    localparam logic [IR_W-1:0]  INS_BUSDATA = 4'hA;
    localparam logic [IR_W-1:0]  INS_CTRL    = 4'hB;
    localparam logic [IR_W-1:0]  IR_CAPTURE  = 4'h1;
    localparam logic [SEQ_W-1:0] SEQ_TO_SW   = 16'hE79E;
    localparam logic [SEQ_W-1:0] SEQ_TO_JTAG = 16'hE73C;
    localparam int CTRL_HALT_BIT = 0;
    localparam int CTRL_STEP_BIT = 1;
    localparam int DATA_RNW_BIT  = 32;

    typedef enum logic [3:0] {
        TS_EXIT2_DR  = 4'h0, TS_EXIT1_DR = 4'h1, TS_SHIFT_DR = 4'h2, TS_PAUSE_DR  = 4'h3,
        TS_SEL_IR    = 4'h4, TS_UPD_DR   = 4'h5, TS_CAP_DR   = 4'h6, TS_SEL_DR    = 4'h7,
        TS_EXIT2_IR  = 4'h8, TS_EXIT1_IR = 4'h9, TS_SHIFT_IR = 4'hA, TS_PAUSE_IR  = 4'hB,
        TS_IDLE      = 4'hC, TS_UPD_IR   = 4'hD, TS_CAP_IR   = 4'hE, TS_RESET     = 4'hF
    } dtdp_tap_st_t;

    typedef struct packed {
        logic              write;
        logic [BUS_AW-1:0] addr;
        logic [BUS_DW-1:0] wdata;
    } dtdp_bus_req_t;

endpackage

// ===== dtdp_probe_model.sv
// Probe model that drives the JTAG link of the debug port
`timescale 1ns/1ps
`default_nettype none
module dtdp_probe_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trstN,
    input  wire logic tdo
);
    initial begin
        tck   = 1'b0;
        tms   = 1'b1;
        tdi   = 1'b0;
        trstN = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One 160 ns clock, pins move at the fall, clock rests low between frames
    task automatic pulse(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        #70 o = tdo;
        #10 tck = 1'b0;
    endtask
    // Scan from idle back to idle, data in and out LSB first
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        #7 pulse(1'b1, tdi, o);
        if (ir) pulse(1'b1, tdi, o);
        pulse(1'b0, tdi, o);
        pulse(1'b0, tdi, o);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], o);
            dout[i] = o;
        end
        pulse(1'b1, tdi, o);
        pulse(1'b0, tdi, o);
        #1 tdi = ~tdi;
    endtask
    // Pin reset or five TMS-high clocks, then on to idle
    task automatic tapReset(input logic pin);
        logic o;
        #7;
        if (pin) begin
            trstN = 1'b0;
            #200 trstN = 1'b1;
        end
        repeat (pin ? 1 : 5) pulse(1'b1, tdi, o);
        pulse(1'b0, tdi, o);
    endtask
    // Line reset of TMS-high clocks, then a 16-bit code LSB first
    task automatic switchSeq(input logic [15:0] s);
        logic o;
        #7;
        repeat (52) pulse(1'b1, tdi, o);
        for (int i = 0; i < 16; i++) pulse(s[i], tdi, o);
    endtask
endmodule // dtdp_probe_model
`default_nettype wire
